// ---- src/tcpd_top.v ----
// The register addresses and the strobed register port were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
`include "tcpd_map.vh"

module tcpd_top #(
    parameter        TWO_AXES = 1,
    parameter [31:0] HOLD_CYC = `TCPD_HOLD_CYC,
    parameter [31:0] DEB_CYC  = `TCPD_DEB_CYC
) (
    input  wire        sys_clk_i,
    input  wire        rst_n_i,
    input  wire        config_input_zero_i,
    input  wire        config_input_one_i,
    input  wire        config_input_two_i,
    input  wire [31:0] angle_i,
    input  wire [3:0]  reg_addr_i,
    input  wire [31:0] reg_wdata_i,
    input  wire        reg_wr_i,
    input  wire        reg_rd_i,
    output wire [31:0] reg_rdata_o,
    output wire [23:0] axis_code_o,
    output wire [1:0]  axis_ovf_o,
    output wire [1:0]  axis_upd_o
);

    localparam [2:0] ST_IDLE = 3'b001;
    localparam [2:0] ST_HOLD = 3'b010;
    localparam [2:0] ST_DONE = 3'b100;
    // reset image of the factory word, bit-selectable per axis
    localparam [31:0] DEF_RST = `TCPD_DEF_RST;

    ////////////////////////////////////////////////////////////////
    // reset release
    // asserts at once, releases on the clock so no flop sees a runt edge
    reg  [1:0]  rst_pipe_reg;
    wire        rst_n;

    always @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rst_pipe_reg <= 2'b00;
        end else begin
            rst_pipe_reg <= {rst_pipe_reg[0], 1'b1};
        end
    end

    assign rst_n = rst_pipe_reg[1];

    ////////////////////////////////////////////////////////////////
    // input synchroniser and debounce
    // settle count masks switch bounce on the level pins
    reg  [2:0]  sync1_reg;
    reg  [2:0]  sync2_reg;
    reg  [2:0]  cand_reg;
    reg  [31:0] deb_cnt_reg;
    reg  [2:0]  pat_reg;

    always @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            sync1_reg   <= 3'h0;
            sync2_reg   <= 3'h0;
            cand_reg    <= 3'h0;
            deb_cnt_reg <= 32'h0000_0000;
            pat_reg     <= 3'h0;
        end else begin
            sync1_reg <= {config_input_two_i, config_input_one_i,
                          config_input_zero_i};
            sync2_reg <= sync1_reg;
            // a bounce restarts the settle count
            if (sync2_reg != cand_reg) begin
                cand_reg    <= sync2_reg;
                deb_cnt_reg <= 32'h0000_0000;
            end else if (deb_cnt_reg < DEB_CYC - 32'h1) begin
                deb_cnt_reg <= deb_cnt_reg + 32'h1;
            end else begin
                pat_reg <= cand_reg;
            end
        end
    end

    ////////////////////////////////////////////////////////////////
    // hold timer
    // counted after debounce, so a command takes slightly over the hold
    reg  [2:0]  state_reg;
    reg  [2:0]  state_next;
    reg  [2:0]  held_reg;
    reg  [2:0]  held_next;
    reg  [31:0] hold_cnt_reg;
    reg  [31:0] hold_cnt_next;
    reg         exec_reg;
    reg         exec_next;
    reg  [2:0]  exec_pat_reg;
    reg  [2:0]  exec_pat_next;

    always @* begin
        state_next    = state_reg;
        held_next     = held_reg;
        hold_cnt_next = hold_cnt_reg;
        exec_next     = 1'b0;
        exec_pat_next = exec_pat_reg;
        case (state_reg)
            ST_IDLE: begin
                if (pat_reg != `TCPD_P_NONE) begin
                    held_next     = pat_reg;
                    hold_cnt_next = 32'h0000_0000;
                    state_next    = ST_HOLD;
                end
            end
            ST_HOLD: begin
                if (pat_reg == `TCPD_P_NONE) begin
                    state_next = ST_IDLE;
                end else if (pat_reg != held_reg) begin
                    // a late second input restarts the hold
                    held_next     = pat_reg;
                    hold_cnt_next = 32'h0000_0000;
                end else if (hold_cnt_reg >= HOLD_CYC - 32'h1) begin
                    exec_next     = 1'b1;
                    exec_pat_next = held_reg;
                    state_next    = ST_DONE;
                end else begin
                    hold_cnt_next = hold_cnt_reg + 32'h1;
                end
            end
            ST_DONE: begin
                // no repeat while any input stays high
                if (pat_reg == `TCPD_P_NONE) begin
                    state_next = ST_IDLE;
                end
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    always @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            state_reg    <= ST_IDLE;
            held_reg     <= 3'h0;
            hold_cnt_reg <= 32'h0000_0000;
            exec_reg     <= 1'b0;
            exec_pat_reg <= 3'h0;
        end else begin
            state_reg    <= state_next;
            held_reg     <= held_next;
            hold_cnt_reg <= hold_cnt_next;
            exec_reg     <= exec_next;
            exec_pat_reg <= exec_pat_next;
        end
    end

    ////////////////////////////////////////////////////////////////
    // command decode
    wire        cmd_def;
    wire        two_ax;

    assign two_ax  = (TWO_AXES != 0);
    assign cmd_def = exec_reg && (exec_pat_reg == `TCPD_P_DEF);

    ////////////////////////////////////////////////////////////////
    // factory settings register
    reg  [31:0] def_reg;
    reg  [31:0] rdata_reg;
    wire [15:0] stat_w;
    wire [31:0] pre_w;

    always @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            def_reg <= `TCPD_DEF_RST;
        end else if (reg_wr_i && reg_addr_i == `TCPD_OFS_DEF) begin
            def_reg <= reg_wdata_i;
        end
    end

    ////////////////////////////////////////////////////////////////
    // per-axis settings and scaling
    genvar a;
    generate
        for (a = 0; a < 2; a = a + 1) begin : g_ax
            wire [2:0]         p_dir;
            wire [2:0]         p_pre;
            wire [2:0]         p_inc;
            wire               en;
            wire               c_dir;
            wire               c_pre;
            wire               c_inc;
            wire [7:0]         dflt;
            wire signed [15:0] ang;
            wire [15:0]        half;
            wire signed [17:0] dev;
            wire signed [17:0] rel;
            wire [16:0]        span;
            wire               ovf;
            wire [26:0]        num;
            wire               ge;
            wire [11:0]        q_nx;
            reg                dir_reg;
            reg  [5:0]         rng_reg;
            reg  signed [15:0] pre_reg;
            reg  [3:0]         cnt_reg;
            reg  [26:0]        rem_reg;
            reg  [26:0]        dsh_reg;
            reg  [11:0]        q_reg;
            reg                ovf_l_reg;
            reg                fine_l_reg;
            reg  [11:0]        rel_l_reg;
            reg  [11:0]        code_reg;
            reg                ovf_reg;
            reg                upd_reg;

            assign p_dir = (a == 0) ? `TCPD_P_DIR0 : `TCPD_P_DIR1;
            assign p_pre = (a == 0) ? `TCPD_P_PRE0 : `TCPD_P_PRE1;
            assign p_inc = (a == 0) ? `TCPD_P_INC0 : `TCPD_P_INC1;
            // single-axis build never decodes second-axis patterns
            assign en    = (a == 0) || two_ax;
            assign c_dir = en && exec_reg && exec_pat_reg == p_dir;
            assign c_pre = en && exec_reg && exec_pat_reg == p_pre;
            assign c_inc = en && exec_reg && exec_pat_reg == p_inc;
            assign dflt  = def_reg[a*`TCPD_AX_STRIDE +: 8];
            assign ang   = angle_i[a*16 +: 16];

            always @(posedge sys_clk_i or negedge rst_n) begin
                if (!rst_n) begin
                    dir_reg <= DEF_RST[a*`TCPD_AX_STRIDE+`TCPD_F_DIR];
                    rng_reg <= DEF_RST[a*`TCPD_AX_STRIDE +: 6];
                    pre_reg <= 16'h0000;
                end else if (cmd_def) begin
                    dir_reg <= dflt[`TCPD_F_DIR];
                    if (dflt[`TCPD_F_RNG_W-1:0] > `TCPD_RNG_MAX) begin
                        // a factory word past the top range is held at the top
                        rng_reg <= `TCPD_RNG_MAX;
                    end else begin
                        rng_reg <= dflt[`TCPD_F_RNG_W-1:0];
                    end
                    pre_reg <= 16'h0000;
                end else if (c_dir) begin
                    dir_reg <= ~dir_reg;
                end else if (c_pre) begin
                    pre_reg <= ang;
                end else if (c_inc) begin
                    if (rng_reg >= `TCPD_RNG_MAX) begin
                        rng_reg <= 6'h00;
                    end else begin
                        rng_reg <= rng_reg + 6'h01;
                    end
                end
            end

            // half span = 5.00 + 2.50 * index degrees
            assign half = `TCPD_HALF_MIN
                        + {10'h000, rng_reg} * `TCPD_HALF_STEP;
            assign span = {half, 1'b0};
            assign dev  = {{2{ang[15]}}, ang} - {{2{pre_reg[15]}}, pre_reg};
            // ccw: rising with angle, cw: falling
            assign rel  = dir_reg ? ({2'b00, half} + dev)
                                  : ({2'b00, half} - dev);
            assign ovf  = rel[17] || (rel > $signed({1'b0, span}));
            // rel * 4095 as shift and subtract
            assign num  = {rel[14:0], 12'h000} - {12'h000, rel[14:0]};
            assign ge   = rem_reg >= dsh_reg;
            assign q_nx = {q_reg[10:0], ge};

            // serial divide: trades latency for no wide divider
            always @(posedge sys_clk_i or negedge rst_n) begin
                if (!rst_n) begin
                    cnt_reg    <= 4'h0;
                    rem_reg    <= 27'h0;
                    dsh_reg    <= 27'h0;
                    q_reg      <= 12'h000;
                    ovf_l_reg  <= 1'b0;
                    fine_l_reg <= 1'b0;
                    rel_l_reg  <= 12'h000;
                    code_reg   <= 12'h000;
                    ovf_reg    <= 1'b0;
                    upd_reg    <= 1'b0;
                end else begin
                    upd_reg <= 1'b0;
                    if (cnt_reg == 4'h0) begin
                        rem_reg    <= num;
                        dsh_reg    <= {1'b0, span[14:0], 11'h000};
                        q_reg      <= 12'h000;
                        ovf_l_reg  <= ovf;
                        fine_l_reg <= span < `TCPD_FINE_SPAN;
                        rel_l_reg  <= rel[11:0];
                        cnt_reg    <= `TCPD_DIV_STEPS;
                    end else begin
                        if (ge) begin
                            rem_reg <= rem_reg - dsh_reg;
                        end
                        dsh_reg <= {1'b0, dsh_reg[26:1]};
                        q_reg   <= q_nx;
                        cnt_reg <= cnt_reg - 4'h1;
                        if (cnt_reg == 4'h1) begin
                            upd_reg <= 1'b1;
                            ovf_reg <= ovf_l_reg;
                            if (ovf_l_reg) begin
                                code_reg <= `TCPD_OVF_CODE;
                            end else if (fine_l_reg) begin
                                // narrow range: one code per 0.01 degree
                                code_reg <= rel_l_reg;
                            end else begin
                                code_reg <= q_nx;
                            end
                        end
                    end
                end
            end

            assign axis_code_o[a*12 +: 12] = code_reg;
            assign axis_ovf_o[a]           = ovf_reg;
            assign axis_upd_o[a]           = upd_reg;
            assign stat_w[a*8 +: 8]        = {ovf_reg, dir_reg, rng_reg};
            assign pre_w[a*16 +: 16]       = pre_reg;
        end
    endgenerate

    ////////////////////////////////////////////////////////////////
    // register read port
    // idle cycles read zero so no stale word lingers on the port
    always @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            rdata_reg <= 32'h0000_0000;
        end else if (reg_rd_i) begin
            case (reg_addr_i)
                `TCPD_OFS_STAT: begin
                    rdata_reg <= {13'h0000, pat_reg, stat_w};
                end
                `TCPD_OFS_DEF: begin
                    rdata_reg <= def_reg;
                end
                `TCPD_OFS_PRE0: begin
                    rdata_reg <= {{16{pre_w[15]}}, pre_w[15:0]};
                end
                `TCPD_OFS_PRE1: begin
                    rdata_reg <= {{16{pre_w[31]}}, pre_w[31:16]};
                end
                default: begin
                    rdata_reg <= 32'h0000_0000;
                end
            endcase
        end else begin
            rdata_reg <= 32'h0000_0000;
        end
    end

    assign reg_rdata_o = rdata_reg;

endmodule

`default_nettype wire

// ---- src/tcpd_map.vh ----
`ifndef TCPD_MAP_VH
`define TCPD_MAP_VH

// clock and timing
`define TCPD_CLK_MHZ    100
`define TCPD_HOLD_MS    4000
`define TCPD_HOLD_CYC   (`TCPD_HOLD_MS * 1000 * `TCPD_CLK_MHZ)
`define TCPD_DEB_MS     10
`define TCPD_DEB_CYC    (`TCPD_DEB_MS * 1000 * `TCPD_CLK_MHZ)

// register offsets
`define TCPD_OFS_STAT   4'h0
`define TCPD_OFS_DEF    4'h4
`define TCPD_OFS_PRE0   4'h8
`define TCPD_OFS_PRE1   4'hC

// factory register: per axis byte, range index [5:0], direction [6]
`define TCPD_AX_STRIDE  8
`define TCPD_F_RNG_W    6
`define TCPD_F_DIR      6
`define TCPD_F_OVF      7
`define TCPD_F_PAT      16
`define TCPD_DEF_RST    32'h0000_6262

// range and scaling, angles in 0.01 degree units
`define TCPD_HALF_MIN   16'h01F4
`define TCPD_HALF_STEP  16'h00FA
`define TCPD_RNG_MAX    6'h22
`define TCPD_FINE_SPAN  17'h01000
`define TCPD_CODE_MAX   12'hFFF
`define TCPD_OVF_CODE   12'hFFF
`define TCPD_DIV_STEPS  4'hC

// input patterns, bit 0 is input zero
`define TCPD_P_NONE     3'h0
`define TCPD_P_DIR0     3'h1
`define TCPD_P_PRE0     3'h2
`define TCPD_P_INC0     3'h4
`define TCPD_P_DIR1     3'h3
`define TCPD_P_PRE1     3'h5
`define TCPD_P_INC1     3'h6
`define TCPD_P_DEF      3'h7

`endif

// ---- bench/tcpd_top_asserts.sv ----
`timescale 1ns/10ps
`default_nettype none
module tcpd_top_chk (
    input wire logic        sys_clk_i,
    input wire logic        rst_n_i,
    input wire logic [3:0]  reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic        reg_wr_i,
    input wire logic        reg_rd_i,
    input wire logic [31:0] reg_rdata_o,
    input wire logic [23:0] axis_code_o,
    input wire logic [1:0]  axis_ovf_o,
    input wire logic [1:0]  axis_upd_o
);
    default clocking @(posedge sys_clk_i);
    endclocking
    default disable iff (!rst_n_i);
    logic [31:0] def_reg;
    ////////////////////////////////
    // shadow of factory word, so readback is judged without a model
    always @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            def_reg <= 32'h0000_6262;
        end else if (reg_wr_i && reg_addr_i == 4'h4) begin
            def_reg <= reg_wdata_i;
        end
    end
    ////////////////////////////////
    // twelve quiet cycles between code loads
    sequence s_gap0;
        !axis_upd_o[0] [*8] ##1 !axis_upd_o[0] [*4];
    endsequence
    sequence s_gap1;
        !axis_upd_o[1] [*8] ##1 !axis_upd_o[1] [*4];
    endsequence
    a_upd_period0 : assert property (axis_upd_o[0] |=> s_gap0 ##1 axis_upd_o[0])
        else $error("axis 0 update period wrong");
    a_upd_period1 : assert property (axis_upd_o[1] |=> s_gap1 ##1 axis_upd_o[1])
        else $error("axis 1 update period wrong");
    a_code_hold0 : assert property (!axis_upd_o[0] |->
        $stable(axis_code_o[11:0]) && $stable(axis_ovf_o[0]))
        else $error("axis 0 code moved without update");
    a_code_hold1 : assert property (!axis_upd_o[1] |->
        $stable(axis_code_o[23:12]) && $stable(axis_ovf_o[1]))
        else $error("axis 1 code moved without update");
    a_ovf_code0 : assert property (axis_ovf_o[0] |-> axis_code_o[11:0] == 12'hFFF)
        else $error("axis 0 overflow without overflow code");
    a_ovf_code1 : assert property (axis_ovf_o[1] |-> axis_code_o[23:12] == 12'hFFF)
        else $error("axis 1 overflow without overflow code");
    a_def_read : assert property ($past(reg_rd_i) && $past(reg_addr_i) == 4'h4
        |-> reg_rdata_o == def_reg)
        else $error("factory word readback wrong");
    a_range_max : assert property ($past(reg_rd_i) && $past(reg_addr_i) == 4'h0
        |-> reg_rdata_o[5:0] <= 6'h22 && reg_rdata_o[13:8] <= 6'h22)
        else $error("range index above maximum");
endmodule
bind tcpd_top tcpd_top_chk chk (
    .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .axis_code_o(axis_code_o), .axis_ovf_o(axis_ovf_o),
    .axis_upd_o(axis_upd_o));
`default_nettype wire

// ---- bench/tcpd_pin_op.sv ----
`timescale 1ns/10ps
`default_nettype none
module tcpd_pin_op (
    input  wire logic       clk_i,
    input  wire logic [2:0] pat_i,
    output logic            zero_o,
    output logic            one_o,
    output logic            two_o
);
    logic [2:0] d1_reg;
    logic [2:0] d2_reg;
    ////////////////////////////////
    // staggered rise, like hands on switches; drop is at once
    always @(posedge clk_i) begin
        d1_reg <= pat_i;
        d2_reg <= d1_reg;
    end
    assign zero_o = pat_i[0];
    assign one_o  = pat_i[1] & d1_reg[1];
    assign two_o  = pat_i[2] & d2_reg[2];
endmodule
`default_nettype wire

// ---- bench/tcpd_top_tb.sv ----
`timescale 1ns/10ps
`default_nettype none
module tcpd_top_tb;
    localparam logic [31:0] HOLD = 32'h32;
    logic        clk    = 1'b0;
    logic        rst_n  = 1'b0;
    logic [2:0]  pat    = 3'h0;
    logic [31:0] angle  = 32'h0;
    logic [3:0]  addr   = 4'h0;
    logic [31:0] wdata  = 32'h0;
    logic        wr     = 1'b0;
    logic        rd     = 1'b0;
    logic        one_ax = 1'b0;
    wire  [2:0]  pin;
    wire  [31:0] rdata;
    wire  [31:0] rdata1;
    wire  [23:0] code;
    wire  [1:0]  ovf;
    wire  [1:0]  upd;
    int          num_errors = 0;
    int          compares   = 0;
    always #5 clk = ~clk;
    tcpd_top #(.TWO_AXES(1), .HOLD_CYC(HOLD), .DEB_CYC(32'h4)) dut (
        .sys_clk_i(clk), .rst_n_i(rst_n), .config_input_zero_i(pin[0]),
        .config_input_one_i(pin[1]), .config_input_two_i(pin[2]), .angle_i(angle),
        .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd),
        .reg_rdata_o(rdata), .axis_code_o(code), .axis_ovf_o(ovf), .axis_upd_o(upd));
    // single-axis variant shares every input
    tcpd_top #(.TWO_AXES(0), .HOLD_CYC(HOLD), .DEB_CYC(32'h4)) dut_one (
        .sys_clk_i(clk), .rst_n_i(rst_n), .config_input_zero_i(pin[0]),
        .config_input_one_i(pin[1]), .config_input_two_i(pin[2]), .angle_i(angle),
        .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd),
        .reg_rdata_o(rdata1), .axis_code_o(), .axis_ovf_o(), .axis_upd_o());
    tcpd_pin_op op (.clk_i(clk), .pat_i(pat), .zero_o(pin[0]), .one_o(pin[1]),
        .two_o(pin[2]));
    ////////////////////////////////
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic reg_rd(input logic [3:0] a, input logic [31:0] exp, input string what);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        check(what, exp, one_ax ? rdata1 : rdata);
    endtask
    // pins low afterwards long enough to rearm
    task automatic cmd(input logic [2:0] p, input logic [31:0] n);
        @(posedge clk);
        pat <= p;
        repeat (n) @(posedge clk);
        pat <= 3'h0;
        repeat (12) @(posedge clk);
    endtask
    task automatic set_angle(input logic [31:0] a);
        @(posedge clk);
        angle <= a;
    endtask
    // 30 cycles cover a full 13-cycle load after any change
    task automatic code_chk(input int ax, input logic [11:0] c, input logic o, input string w);
        repeat (30) @(negedge clk);
        check(w, {19'h0, o, c}, {19'h0, ovf[ax], code[ax*12 +: 12]});
    endtask
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    ////////////////////////////////
    initial begin
        #100000;
        num_errors++;
        complete_run();
    end
    initial begin
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        reg_rd(4'h0, 32'h0000_6262, "stat");
        reg_rd(4'h4, 32'h0000_6262, "def");
        reg_wr(4'h0, 32'hFFFF_FFFF);
        reg_rd(4'h0, 32'h0000_6262, "stat ro");
        reg_rd(4'h2, 32'h0, "unmapped");
        code_chk(0, 12'h7FF, 1'b0, "mid code");
        $display("test reset done");
        cmd(3'h1, 3 * HOLD);
        reg_rd(4'h0, 32'h0000_6222, "dir0 once");
        set_angle(32'h0000_0708);
        code_chk(0, 12'h666, 1'b0, "cw slope");
        $display("test direction done");
        cmd(3'h4, 32'h50);
        reg_rd(4'h0, 32'h0000_6280, "wrap");
        code_chk(0, 12'hFFF, 1'b1, "overflow");
        cmd(3'h4, 32'h50);
        reg_rd(4'h0, 32'h0000_6281, "step");
        set_angle(32'h0000_0064);
        code_chk(0, 12'h28A, 1'b0, "fine step");
        $display("test range done");
        set_angle(32'h0000_0320);
        cmd(3'h2, 32'h50);
        reg_rd(4'h8, 32'h0000_0320, "pre0");
        code_chk(0, 12'h2EE, 1'b0, "centre");
        // short hold then a new pattern: only the second acts
        @(posedge clk);
        pat <= 3'h1;
        repeat (30) @(posedge clk);
        cmd(3'h4, 32'h50);
        reg_rd(4'h0, 32'h0000_6202, "restart");
        $display("test preset done");
        cmd(3'h3, 32'h50);
        cmd(3'h6, 32'h50);
        set_angle(32'hFF38_0320);
        cmd(3'h5, 32'h50);
        reg_rd(4'h0, 32'h0000_0002, "axis1");
        reg_rd(4'hC, 32'hFFFF_FF38, "pre1");
        code_chk(1, 12'h1F4, 1'b0, "axis1 code");
        one_ax = 1'b1;
        reg_rd(4'h0, 32'h0000_6202, "one axis");
        reg_rd(4'hC, 32'h0, "one axis pre1");
        one_ax = 1'b0;
        $display("test second axis done");
        reg_wr(4'h4, 32'h0000_4105);
        reg_rd(4'h4, 32'h0000_4105, "def rw");
        cmd(3'h7, 32'h50);
        reg_rd(4'h0, 32'h0000_4105, "restore");
        reg_rd(4'h8, 32'h0, "pre0 cleared");
        code_chk(0, 12'h3B6, 1'b0, "restored code");
        reg_wr(4'h4, 32'h0000_007F);
        cmd(3'h7, 32'h50);
        reg_rd(4'h0, 32'h0000_0062, "restore clamp");
        $display("test restore done");
        complete_run();
    end
endmodule
`default_nettype wire
